// ==== src/pues_defs.svh ====
// Constants for the power-up event sequencer
`ifndef PUES_DEFS_SVH
`define PUES_DEFS_SVH

// Register byte offsets
`define PUES_OFF_CTRL      12'h000
`define PUES_OFF_STATUS    12'h004
`define PUES_OFF_TBASE     12'h008
`define PUES_OFF_SLOT_BASE 12'h010

// Control register fields
`define PUES_CTRL_DEEP_OFF_BIT 0
`define PUES_CTRL_PDONE_BIT    1

// Reset values
`define PUES_CTRL_RST      1'b0
`define PUES_TBASE_RST     2'h0

// Number of sequenced outputs: 4 switchers, 3 LDOs, power good, host reset
`define PUES_N_SW          4
`define PUES_N_LDO         3
`define PUES_N_OUT         9
`define PUES_IDX_POWER_GOOD_PIN     7
`define PUES_IDX_RESET     8

// Timing (clock 25 MHz)
`define PUES_CLK_MHZ       25
`define PUES_T_FUSE_US     600
`define PUES_T_STEST_US    700
`define PUES_T_FIRST_US    100
`define PUES_TICK_US       10
`define PUES_FUSE_CYC      (`PUES_T_FUSE_US * `PUES_CLK_MHZ)
`define PUES_STEST_CYC     (`PUES_T_STEST_US * `PUES_CLK_MHZ / 2)
`define PUES_FIRST_CYC     (`PUES_T_FIRST_US * `PUES_CLK_MHZ / 4)
`define PUES_TICK_CYC      (`PUES_TICK_US * `PUES_CLK_MHZ)

// Time base in ticks: 30, 120, 250, 500 us
`define PUES_TB0_TICKS     8'd3
`define PUES_TB1_TICKS     8'd12
`define PUES_TB2_TICKS     8'd25
`define PUES_TB3_TICKS     8'd50

`endif

// ==== src/pues_pkg.sv ====
// Types for the power-up event sequencer
package pues_pkg;

  typedef enum logic [2:0] {
    PUES_ST_FUSE  = 3'b000,
    PUES_ST_OFF   = 3'b001,
    PUES_ST_STEST = 3'b011,
    PUES_ST_FIRST = 3'b010,
    PUES_ST_SEQ   = 3'b110,
    PUES_ST_RUN   = 3'b111
  } pues_state_t;

  typedef struct packed {
    logic       edge_mode;
    logic       ovlo_sdwn_default;
    logic [1:0] tbase;
    logic [8:0][7:0] slot;
  } pues_fuse_t;

  typedef struct packed {
    logic uv_ok;
    logic ovlo_trip;
    logic ovlo_en;
    logic tsd;
    logic trim_invalid;
    logic fuse_invalid;
  } pues_mon_t;

endpackage

// ==== src/pues_sync.sv ====
// Two flip-flop synchroniser for one level
`timescale 1ns/1ns
`default_nettype none
module pues_sync
(
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic meta;

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta <= 1'b0;
      q_o  <= 1'b0;
    end
    else
    begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule
`default_nettype wire

// ==== src/pues_top.sv ====
// Power-up event qualifier and slotted sequencer with APB registers
//
// Implementation choices: the APB register port and the register offsets.
`include "pues_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module pues_top
(
  input  wire logic                sys_clk_i,
  input  wire logic                rst_n_i,
  input  wire logic                psel_i,
  input  wire logic                penable_i,
  input  wire logic                pwrite_i,
  input  wire logic [11:0]         paddr_i,
  input  wire logic [31:0]         pwdata_i,
  output logic [31:0]              prdata_o,
  output logic                     pready_o,
  output logic                     pslverr_o,
  input  wire logic                power_on_request_pin_i,
  input  wire logic                undervoltage_detect_i,
  input  wire logic                input_overvoltage_lockout_i,
  input  wire logic                ovlo_enable_i,
  input  wire logic                thermal_shutdown_i,
  input  wire logic                trim_invalid_flag_i,
  input  wire logic                fuse_invalid_flag_i,
  input  wire pues_pkg::pues_fuse_t fuse_i,
  input  wire logic [15:0]         on_pin_debounce_time_i,
  output logic [3:0]               switcher_en_o,
  output logic [2:0]               linear_reg_en_o,
  output logic                     power_good_pin_o,
  output logic                     host_reset_out_n_o,
  output logic                     fuse_load_done_o,
  output logic                     self_test_done_o,
  output logic                     deep_off_state_o,
  output logic                     slave_mode_o,
  output logic                     power_up_done_o
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic pin_s;
  logic uv_s;
  logic ovlo_s;
  logic tsd_s;

  pues_sync u_sync_pin
  (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .d_i       (power_on_request_pin_i),
    .q_o       (pin_s)
  );

  pues_sync u_sync_uv
  (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .d_i       (undervoltage_detect_i),
    .q_o       (uv_s)
  );

  pues_sync u_sync_ovlo
  (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .d_i       (input_overvoltage_lockout_i),
    .q_o       (ovlo_s)
  );

  pues_sync u_sync_tsd
  (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .d_i       (thermal_shutdown_i),
    .q_o       (tsd_s)
  );

  ////////////////////////////////////////////////////////////////////////
  // State and storage
  pues_pkg::pues_state_t state;
  pues_pkg::pues_state_t next_state;
  pues_pkg::pues_mon_t   mon;
  logic                  uv_q;
  logic                  pin_q;
  logic                  deep_off;
  logic                  pdone;
  logic [1:0]            tbase;
  logic [7:0]            slot [`PUES_N_OUT];
  logic [`PUES_N_OUT-1:0] out_en;
  logic [15:0]           wait_cnt;
  logic [15:0]           dbnc_cnt;
  logic                  dbnc_arm;
  logic [7:0]            tick_cnt;
  logic [7:0]            tb_cnt;
  logic [7:0]            slot_num;

  assign mon = '{uv_ok: uv_s, ovlo_trip: ovlo_s, ovlo_en: ovlo_enable_i, tsd: tsd_s,
                 trim_invalid: trim_invalid_flag_i, fuse_invalid: fuse_invalid_flag_i};

  ////////////////////////////////////////////////////////////////////////
  // Event qualification
  wire uv_rise   = uv_s && !uv_q;
  wire ovlo_bad  = mon.ovlo_trip && mon.ovlo_en && fuse_i.ovlo_sdwn_default;
  wire ev_ok     = mon.uv_ok && !ovlo_bad && !mon.tsd
                   && !mon.trim_invalid && !mon.fuse_invalid;
  wire pin_fall  = pin_q && !pin_s;
  wire dbnc_hit  = dbnc_arm && !pin_s && (dbnc_cnt >= on_pin_debounce_time_i);
  wire raw_ev    = fuse_i.edge_mode ? dbnc_hit : pin_s;
  wire power_ev  = raw_ev && ev_ok;

  ////////////////////////////////////////////////////////////////////////
  // Slot bookkeeping
  logic [7:0] max_reg_code;
  logic       any_reg;
  always_comb
  begin
    max_reg_code = 8'h00;
    for (int i = 0; i < `PUES_IDX_RESET; i++)
    begin
      if (slot[i] > max_reg_code)
        max_reg_code = slot[i];
    end
    any_reg = (max_reg_code != 8'h00);
  end

  wire [7:0] last_slot  = (max_reg_code == 8'h00) ? 8'h00 : max_reg_code - 8'h01;
  wire       rst_slotted = (slot[`PUES_IDX_RESET] != 8'h00);
  wire [7:0] end_slot   = (rst_slotted && slot[`PUES_IDX_RESET] > max_reg_code) ?
                          slot[`PUES_IDX_RESET] : max_reg_code;
  wire [7:0] tb_ticks   = (tbase == 2'h0) ? `PUES_TB0_TICKS :
                          (tbase == 2'h1) ? `PUES_TB1_TICKS :
                          (tbase == 2'h2) ? `PUES_TB2_TICKS : `PUES_TB3_TICKS;
  wire       tick       = (tick_cnt == 8'(`PUES_TICK_CYC - 1));
  wire       tb_step    = tick && (tb_cnt == tb_ticks - 8'h01);
  wire       seq_end    = tb_step && (slot_num >= end_slot - 8'h01);

  ////////////////////////////////////////////////////////////////////////
  // State machine
  always_comb
  begin
    next_state = state;
    unique case (state)
      pues_pkg::PUES_ST_FUSE:
        if (wait_cnt == 16'(`PUES_FUSE_CYC - 1))
          next_state = pues_pkg::PUES_ST_OFF;
      pues_pkg::PUES_ST_OFF:
        if (power_ev)
          next_state = deep_off ? pues_pkg::PUES_ST_FIRST : pues_pkg::PUES_ST_STEST;
      pues_pkg::PUES_ST_STEST:
        if (wait_cnt == 16'(`PUES_STEST_CYC - 1))
          next_state = pues_pkg::PUES_ST_FIRST;
      pues_pkg::PUES_ST_FIRST:
        if (wait_cnt == 16'(`PUES_FIRST_CYC - 1))
          next_state = any_reg ? pues_pkg::PUES_ST_SEQ : pues_pkg::PUES_ST_RUN;
      pues_pkg::PUES_ST_SEQ:
        if (seq_end)
          next_state = pues_pkg::PUES_ST_RUN;
      pues_pkg::PUES_ST_RUN:
        next_state = pues_pkg::PUES_ST_RUN;
      default:
        next_state = pues_pkg::PUES_ST_FUSE;
    endcase
    if (uv_rise || !uv_s)
      next_state = uv_s ? pues_pkg::PUES_ST_FUSE : pues_pkg::PUES_ST_FUSE;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      state <= pues_pkg::PUES_ST_FUSE;
    else
      state <= next_state;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      wait_cnt <= 16'h0000;
    else if (next_state != state || !uv_s)
      wait_cnt <= 16'h0000;
    else
      wait_cnt <= wait_cnt + 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////////
  // Edge history and debounce
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      uv_q     <= 1'b0;
      pin_q    <= 1'b0;
      dbnc_arm <= 1'b0;
      dbnc_cnt <= 16'h0000;
    end
    else
    begin
      uv_q  <= uv_s;
      pin_q <= pin_s;
      if (pin_fall)
      begin
        dbnc_arm <= 1'b1;
        dbnc_cnt <= 16'h0000;
      end
      else if (pin_s || state != pues_pkg::PUES_ST_OFF)
        dbnc_arm <= 1'b0;
      else if (dbnc_cnt != 16'hffff)
        dbnc_cnt <= dbnc_cnt + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Slot timer
  wire seq_run = (state == pues_pkg::PUES_ST_SEQ);
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tick_cnt <= 8'h00;
      tb_cnt   <= 8'h00;
      slot_num <= 8'h00;
    end
    else if (!seq_run)
    begin
      tick_cnt <= 8'h00;
      tb_cnt   <= 8'h00;
      slot_num <= 8'h00;
    end
    else
    begin
      tick_cnt <= tick ? 8'h00 : tick_cnt + 8'h01;
      if (tb_step)
      begin
        tb_cnt   <= 8'h00;
        slot_num <= slot_num + 8'h01;
      end
      else if (tick)
        tb_cnt <= tb_cnt + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output enables
  wire in_off = (state == pues_pkg::PUES_ST_FUSE) || (state == pues_pkg::PUES_ST_OFF);
  wire in_run = (state == pues_pkg::PUES_ST_RUN);
  wire reg_done = seq_run && (slot_num > last_slot);

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      out_en <= '0;
    else if (in_off)
      out_en <= '0;
    else
    begin
      for (int i = 0; i < `PUES_N_OUT; i++)
      begin
        if (seq_run && slot[i] != 8'h00 && slot_num == slot[i] - 8'h01)
          out_en[i] <= 1'b1;
      end
      if (!rst_slotted && (reg_done || in_run))
        out_en[`PUES_IDX_RESET] <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB registers
  wire acc    = psel_i && penable_i;
  wire wr     = acc && pwrite_i;
  wire hit_ctrl  = (paddr_i == `PUES_OFF_CTRL);
  wire hit_stat  = (paddr_i == `PUES_OFF_STATUS);
  wire hit_tb    = (paddr_i == `PUES_OFF_TBASE);
  wire [11:0] sl_off = paddr_i - `PUES_OFF_SLOT_BASE;
  wire hit_slot  = (paddr_i >= `PUES_OFF_SLOT_BASE) && (sl_off[1:0] == 2'h0)
                   && (sl_off[11:2] < 10'(`PUES_N_OUT));
  wire [3:0] sl_idx = sl_off[5:2];
  wire sys_on = !in_off;
  wire mapped = hit_ctrl || hit_stat || hit_tb || hit_slot;

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      deep_off <= `PUES_CTRL_RST;
      pdone    <= 1'b0;
      tbase    <= `PUES_TBASE_RST;
      for (int i = 0; i < `PUES_N_OUT; i++)
        slot[i] <= 8'h00;
    end
    else
    begin
      if (uv_rise)
        deep_off <= 1'b0;
      else if (wr && hit_ctrl && in_run)
        deep_off <= pwdata_i[`PUES_CTRL_DEEP_OFF_BIT];
      if (state == pues_pkg::PUES_ST_SEQ && seq_end)
        pdone <= 1'b1;
      else if (wr && hit_ctrl && pwdata_i[`PUES_CTRL_PDONE_BIT])
        pdone <= 1'b0;
      if (in_off)
      begin
        tbase <= fuse_i.tbase;
        for (int i = 0; i < `PUES_N_OUT; i++)
          slot[i] <= fuse_i.slot[i];
      end
      else if (wr && sys_on && hit_tb)
        tbase <= pwdata_i[1:0];
      else if (wr && sys_on && hit_slot)
        slot[sl_idx] <= pwdata_i[7:0];
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      prdata_o <= 32'h0000_0000;
    else if (psel_i && !penable_i && !pwrite_i)
      prdata_o <= hit_ctrl ? {30'h0, pdone, deep_off} :
                  hit_stat ? {23'h0, (in_run && !any_reg), state, 5'(out_en[4:0])} :
                  hit_tb   ? {30'h0, tbase} :
                  hit_slot ? {24'h0, slot[sl_idx]} : 32'h0000_0000;
  end

  assign pready_o  = 1'b1;
  assign pslverr_o = acc && !mapped;

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign switcher_en_o      = out_en[3:0];
  assign linear_reg_en_o    = out_en[6:4];
  assign power_good_pin_o   = out_en[`PUES_IDX_POWER_GOOD_PIN];
  assign host_reset_out_n_o = out_en[`PUES_IDX_RESET];
  assign fuse_load_done_o   = (state != pues_pkg::PUES_ST_FUSE);
  assign self_test_done_o   = (state == pues_pkg::PUES_ST_FIRST) || seq_run || in_run;
  assign deep_off_state_o   = (state == pues_pkg::PUES_ST_OFF) && !deep_off;
  assign slave_mode_o       = in_run && !any_reg;
  assign power_up_done_o    = pdone;

endmodule
`default_nettype wire

// ==== test/pues_host_model.sv ====
// Host processor model: drives the power-on pin, watches host reset
`timescale 1ns/1ns
`default_nettype none
module pues_host_model
(
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  input  wire logic want_on_i,
  input  wire logic host_reset_out_n_i,
  output logic      power_on_request_pin_o,
  output logic      booted_o
);
  ////////////////////////////////////////////////////////////////////////////
  // Pin level held by host, changed only after a clock edge
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      power_on_request_pin_o <= 1'b0;
      booted_o               <= 1'b0;
    end
    else
    begin
      power_on_request_pin_o <= want_on_i;
      booted_o               <= host_reset_out_n_i;
    end
  end
endmodule
`default_nettype wire

// ==== test/pues_top_chk.sv ====
// Assertion checker for the power-up event sequencer
`timescale 1ns/1ns
`default_nettype none
module pues_chk
(
  input wire logic                 sys_clk_i,
  input wire logic                 rst_n_i,
  input wire logic                 psel_i,
  input wire logic                 penable_i,
  input wire logic                 pwrite_i,
  input wire logic [11:0]          paddr_i,
  input wire logic [31:0]          pwdata_i,
  input wire logic                 undervoltage_detect_i,
  input wire pues_pkg::pues_fuse_t fuse_i,
  input wire logic [3:0]           switcher_en_o,
  input wire logic [2:0]           linear_reg_en_o,
  input wire logic                 power_good_pin_o,
  input wire logic                 host_reset_out_n_o,
  input wire logic                 fuse_load_done_o,
  input wire logic                 self_test_done_o,
  input wire logic                 slave_mode_o,
  input wire logic                 power_up_done_o
);
  localparam int FUSE_LIM = 15004;
  logic [15:0] fuse_cnt;
  wire         any_en = (|switcher_en_o) | (|linear_reg_en_o) | power_good_pin_o;
  wire         clr_done = psel_i & penable_i & pwrite_i & (paddr_i == 12'h000) & pwdata_i[1];
  ////////////////////////////////////////////////////////////////////////////
  // Cycles spent loading fuses
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      fuse_cnt <= 16'h0000;
    else if (undervoltage_detect_i && !fuse_load_done_o)
      fuse_cnt <= fuse_cnt + 16'h0001;
    else
      fuse_cnt <= 16'h0000;
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////////////////////
  AST_FUSE_TIME: assert property (fuse_cnt <= FUSE_LIM)
    else $error("fuse load too slow");
  AST_UV_HOLD: assert property ((!undervoltage_detect_i)[*6] |-> !fuse_load_done_o)
    else $error("state left fuse load while input low");
  AST_NOTHING_BEFORE_TEST: assert property ($rose(self_test_done_o) |-> !any_en)
    else $error("output on before self-test");
  AST_FIRST_SLOT: assert property ($rose(self_test_done_o) && fuse_i.slot[0] == 8'h01
    |-> ##[1:1000] switcher_en_o[0])
    else $error("first slot late");
  AST_EXCL_PG: assert property (fuse_i.slot[7] == 8'h00 |-> !power_good_pin_o)
    else $error("excluded power good driven");
  AST_EXCL_SW: assert property (fuse_i.slot[2] == 8'h00 |-> !switcher_en_o[2])
    else $error("excluded switcher enabled");
  AST_RESET_AFTER_REG: assert property ($rose(host_reset_out_n_o) && fuse_i.slot[8] == 8'h00
    && !slave_mode_o |-> any_en)
    else $error("reset released before regulators");
  AST_SLAVE_NO_EN: assert property (slave_mode_o |-> !any_en)
    else $error("output enabled in slave mode");
  AST_SLAVE_RESET: assert property ($rose(slave_mode_o) && fuse_i.slot[8] == 8'h00
    |-> ##[0:2] host_reset_out_n_o)
    else $error("slave mode reset not released");
  AST_DONE_STICKY: assert property (power_up_done_o && fuse_load_done_o && undervoltage_detect_i
    && !clr_done |=> power_up_done_o)
    else $error("completion flag lost");
endmodule
bind pues_top pues_chk u_pues_chk
(
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .undervoltage_detect_i(undervoltage_detect_i), .fuse_i(fuse_i),
  .switcher_en_o(switcher_en_o), .linear_reg_en_o(linear_reg_en_o),
  .power_good_pin_o(power_good_pin_o), .host_reset_out_n_o(host_reset_out_n_o),
  .fuse_load_done_o(fuse_load_done_o), .self_test_done_o(self_test_done_o),
  .slave_mode_o(slave_mode_o), .power_up_done_o(power_up_done_o)
);
`default_nettype wire

// ==== test/pues_top_bench.sv ====
// Directed testbench for the power-up event sequencer
`timescale 1ns/1ns
`default_nettype none
module pues_top_bench;
  logic                 sys_clk_i, rst_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic [11:0]          paddr_i;
  logic [31:0]          pwdata_i, prdata_o, rd;
  logic                 err, want_on, pin, booted, uv, ovlo, ovlo_en, tsd, trim_inv, fuse_inv;
  logic [15:0]          dbnc;
  pues_pkg::pues_fuse_t fuse;
  logic [3:0]           sw;
  logic [2:0]           ldo;
  logic                 pg, rst_out_n, fl_done, st_done, deep, slave, pu_done;
  wire  [7:0]           mon = {slave, pu_done, rst_out_n, sw[1], ldo[0], sw[0], st_done, fl_done};
  int                   errors, num_checks, cyc, t0, t1, t2, t3, t4;
  ////////////////////////////////////////////////////////////////////////////
  pues_top u_pues_top (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .power_on_request_pin_i(pin), .undervoltage_detect_i(uv),
    .input_overvoltage_lockout_i(ovlo), .ovlo_enable_i(ovlo_en), .thermal_shutdown_i(tsd),
    .trim_invalid_flag_i(trim_inv), .fuse_invalid_flag_i(fuse_inv), .fuse_i(fuse),
    .on_pin_debounce_time_i(dbnc), .switcher_en_o(sw), .linear_reg_en_o(ldo),
    .power_good_pin_o(pg), .host_reset_out_n_o(rst_out_n), .fuse_load_done_o(fl_done),
    .self_test_done_o(st_done), .deep_off_state_o(deep), .slave_mode_o(slave),
    .power_up_done_o(pu_done));
  pues_host_model u_pues_host_model (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .want_on_i(want_on), .host_reset_out_n_i(rst_out_n), .power_on_request_pin_o(pin),
    .booted_o(booted));
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) cyc <= cyc + 1;
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic fail(input string what);
    errors++;
    $display("ERROR at %0t: %s", $time, what);
  endtask
  task automatic check_bit(input logic got, input logic exp, input string what);
    num_checks++;
    if (got !== exp)
      fail(what);
  endtask
  task automatic check32(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp)
      fail(what);
  endtask
  task automatic check_rng(input int v, input int lo, input int hi, input string what);
    num_checks++;
    if (v < lo || v > hi)
      fail(what);
  endtask
  task automatic wait_sig(input int sel, input int lim, output int t);
    int n;
    n = 0;
    while (mon[sel] !== 1'b1 && n < lim)
    begin
      @(negedge sys_clk_i);
      n++;
    end
    t = cyc;
    if (n >= lim)
    begin
      fail("wait timed out");
      test_done();
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= wr;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    do
    begin
      @(posedge sys_clk_i);
      n++;
    end
    while (pready_o !== 1'b1 && n < 20);
    rd = prdata_o;
    err = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    if (n >= 20)
    begin
      fail("bus timed out");
      test_done();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {psel_i, penable_i, pwrite_i, want_on, ovlo, ovlo_en, tsd, trim_inv, fuse_inv} = '0;
    {paddr_i, pwdata_i, errors, num_checks, cyc} = '0;
    rst_n_i = 1'b0;
    uv = 1'b1;
    dbnc = 16'h0064;
    fuse = '0;
    fuse.ovlo_sdwn_default = 1'b1;
    fuse.slot[0] = 8'h01;  // Switcher 0 enabled in the first slot
    fuse.slot[4] = 8'h02;
    fuse.slot[1] = 8'h03;
    repeat (12) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    t0 = cyc;
    apb(1'b0, 12'h000, 32'h0);
    check_bit(rd[0], 1'b0, "control after power cycle");
    apb(1'b0, 12'h00c, 32'h0);
    check_bit(err, 1'b1, "unmapped access accepted");
    wait_sig(0, 16000, t1);
    check_rng(t1 - t0, 0, 15004, "fuse load time");
    $display("test reset done");
    for (int k = 0; k < 4; k++)
    begin
      @(posedge sys_clk_i);
      {ovlo_en, ovlo, tsd, trim_inv, fuse_inv} <= (k == 0) ? 5'h18 : (5'h04 >> (k - 1));
      want_on <= 1'b1;
      repeat (300) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      check_bit(deep, 1'b1, "event taken with bad monitor");
      @(posedge sys_clk_i);
      want_on <= 1'b0;
      repeat (10) @(posedge sys_clk_i);
      {ovlo_en, ovlo, tsd, trim_inv, fuse_inv} <= 5'h08;
      repeat (10) @(posedge sys_clk_i);
    end
    $display("test monitors done");
    want_on <= 1'b1;
    t0 = cyc;
    wait_sig(1, 18000, t1);
    check_rng(t1 - t0, 1, 17500, "self-test time");
    wait_sig(2, 3000, t2);
    check_rng(t2 - t1, 1, 2500, "first slot time");
    wait_sig(3, 1000, t3);
    check_rng(t3 - t2, 500, 750, "slot 1 spacing");
    wait_sig(4, 1000, t4);
    check_rng(t4 - t3, 750, 750, "slot 2 spacing");
    wait_sig(5, 1000, t0);
    check_rng(t0 - t4, 0, 750, "reset not after last regulator");
    check_rng(t0 - t2, 0, 37500, "reset too late after first regulator");
    wait_sig(6, 1000, t0);
    check_rng(t0 - t4, 500, 752, "completion time");
    check32({27'h0, pg, sw[3:2], ldo[2:1]}, 32'h0, "excluded output on");
    check_bit(slave, 1'b0, "slave mode with slots");
    $display("test sequence done");
    apb(1'b1, 12'h008, 32'h3);
    apb(1'b0, 12'h008, 32'h0);
    check32(rd & 32'h3, 32'h3, "time base rewrite");
    apb(1'b1, 12'h024, 32'h7);
    apb(1'b0, 12'h024, 32'h0);
    check32(rd & 32'hff, 32'h7, "slot rewrite");
    apb(1'b1, 12'h000, 32'h3);
    apb(1'b0, 12'h000, 32'h0);
    check_bit(rd[0], 1'b1, "deep-off bit write");
    check_bit(pu_done, 1'b0, "completion flag clear");
    $display("test registers done");
    uv   <= 1'b0;
    fuse <= {1'b1, 75'h0};
    repeat (20) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    check_bit(fl_done, 1'b0, "input low left fuse load");
    @(posedge sys_clk_i);
    uv <= 1'b1;
    wait_sig(0, 16000, t0);
    apb(1'b0, 12'h000, 32'h0);
    check_bit(rd[0], 1'b0, "deep-off bit kept over power cycle");
    apb(1'b0, 12'h008, 32'h0);
    check32(rd & 32'h3, 32'h0, "time base not reloaded");
    apb(1'b0, 12'h024, 32'h0);
    check32(rd & 32'hff, 32'h0, "slot not reloaded");
    want_on <= 1'b0;
    repeat (20) @(posedge sys_clk_i);
    want_on <= 1'b1;
    repeat (300) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    check_bit(deep, 1'b1, "short low or high level taken in edge mode");
    @(posedge sys_clk_i);
    want_on <= 1'b0;
    t0 = cyc;
    wait_sig(1, 18000, t1);
    check_rng(t1 - t0, 100, 17600, "edge event timing");
    wait_sig(7, 4000, t2);
    repeat (2) @(negedge sys_clk_i);
    check32({28'h0, sw[0], ldo[0], pg, rst_out_n}, 32'h1, "slave mode outputs");
    check_bit(booted, 1'b1, "host never saw reset release");
    $display("test slave done");
    test_done();
  end
endmodule
`default_nettype wire
